// >>> dv/reset_seq_monitor.sv
// Purpose: port checker for the reset sequencer
// Assumes: one pclk domain, presetn async active low
// Notes:   bound to every sequencer instance
`default_nettype none

module reset_seq_monitor (
    // clock and reset
    input wire logic        pclk,
    input wire logic        presetn,
    // apb and pin
    input wire logic        pslverr,
    input wire logic        rst_pin_out,
    input wire logic        rst_pin_oe,
    // core and peripherals
    input wire logic        core_reset_n,
    input wire logic        sfr_reset_n,
    input wire logic        ram_reset_n,
    input wire logic [15:0] fetch_address,
    input wire logic        osc_internal_sel,
    input wire logic        watchdog_enable,
    input wire logic [3:0]  watchdog_clk_div,
    input wire logic        irq_timer_enable,
    input wire logic [7:0]  port_latch,
    input wire logic        port_open_drain,
    input wire logic        weak_pullup_en,
    input wire logic        irq
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    AST_HALT: assert property (
        !core_reset_n |-> !sfr_reset_n && !irq_timer_enable)
        else $error("core or timers active in reset");
    AST_RAM: assert property (ram_reset_n)
        else $error("data memory reset");
    AST_LATCH: assert property (!core_reset_n |->
        port_latch == 8'hFF && port_open_drain && weak_pullup_en)
        else $error("port defaults wrong in reset");
    AST_DRIVE: assert property (
        rst_pin_oe |-> !core_reset_n && !rst_pin_out)
        else $error("pin driven outside reset");
    AST_HOLD: assert property (
        $fell(rst_pin_oe) |-> $rose(core_reset_n))
        else $error("pin released before reset exit");
    AST_EXIT: assert property ($rose(core_reset_n) |->
        osc_internal_sel && watchdog_enable && watchdog_clk_div == 4'hC)
        else $error("clock or watchdog wrong at exit");
    AST_FETCH: assert property (
        !$past(core_reset_n) |-> fetch_address == 16'h0000)
        else $error("fetch address not zero");
    AST_SYNC: assert property (
        $rose(core_reset_n) |-> $rose(sfr_reset_n))
        else $error("registers left reset on different edges");

    COV_EXIT: cover property ($rose(core_reset_n));
    COV_ENTER: cover property ($fell(core_reset_n));
    COV_IRQ: cover property ($rose(irq));
    COV_ERR: cover property (pslverr);
endmodule

bind reset_source_sequencer reset_seq_monitor reset_seq_monitor_i (
    .pclk, .presetn, .pslverr, .rst_pin_out, .rst_pin_oe,
    .core_reset_n, .sfr_reset_n, .ram_reset_n, .fetch_address,
    .osc_internal_sel, .watchdog_enable, .watchdog_clk_div,
    .irq_timer_enable, .port_latch, .port_open_drain,
    .weak_pullup_en, .irq
);
`default_nettype wire

// >>> dv/supply_pin_model.sv
// Purpose: supply comparator and reset pin circuit
// Assumes: pin has an outside pull-up
// Notes:   comparator output follows supply_ok one edge later
`default_nettype none

module supply_pin_model (
    // clock and controls
    input  wire logic pclk,
    input  wire logic supply_ok,
    input  wire logic ext_low,
    // sequencer side
    input  wire logic rst_pin_out,
    input  wire logic rst_pin_oe,
    output var  logic supply_above,
    output wire logic rst_pin_in
);
    timeunit 1ns;
    timeprecision 1ps;

    initial supply_above = 1'b0;
    always @(posedge pclk) begin
        supply_above <= supply_ok;
    end
    // pulled up unless either party pulls low
    assign rst_pin_in = !((rst_pin_oe && !rst_pin_out) || ext_low);
endmodule
`default_nettype wire

// >>> dv/test_reset_source_sequencer.sv
// Purpose: self-checking bench for the reset sequencer
// Assumes: short power-on delay for simulation
// Notes:   supply and pin reach the block through the model
`default_nettype none
`include "reset_seq_map.vh"

module test_reset_source_sequencer;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int DLY = 8;

    logic        pclk, presetn, psel, penable, pwrite;
    logic        supply_ok, ext_low, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, rd;
    wire  [31:0] prdata;
    wire  [15:0] fetch_address;
    wire  [7:0]  port_latch;
    wire  [3:0]  watchdog_clk_div;
    wire         pready, pslverr, supply_above, supply_monitor_enable;
    wire         supply_threshold_high, rst_pin_in, rst_pin_out;
    wire         rst_pin_oe, core_reset_n, sfr_reset_n, ram_reset_n;
    wire         osc_internal_sel, watchdog_enable, irq_timer_enable;
    wire         port_open_drain, weak_pullup_en, irq;
    int          fail_count, comparisons, n;

    reset_source_sequencer #(.POR_DELAY_CYCLES(DLY))
    reset_source_sequencer_i (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .supply_above,
        .supply_monitor_enable, .supply_threshold_high, .rst_pin_in,
        .rst_pin_out, .rst_pin_oe, .core_reset_n, .sfr_reset_n,
        .ram_reset_n, .fetch_address, .osc_internal_sel,
        .watchdog_enable, .watchdog_clk_div, .irq_timer_enable,
        .port_latch, .port_open_drain, .weak_pullup_en, .irq
    );
    supply_pin_model supply_pin_model_i (
        .pclk, .supply_ok, .ext_low, .rst_pin_out, .rst_pin_oe,
        .supply_above, .rst_pin_in
    );

    // ----------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------
    task automatic conclude();
        if (fail_count == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic check32(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic check1(input logic got, input logic exp);
        check32({31'h0, got}, {31'h0, exp});
    endtask
    task automatic apb(input logic [11:0] a, input logic w,
                       input logic [31:0] d);
        int k;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (pready !== 1'b1) begin
            fail_count++;
            conclude();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic wait_core(input logic lvl);
        n = 0;
        while (core_reset_n !== lvl && n < 2000) begin
            @(posedge pclk);
            n++;
        end
        if (core_reset_n !== lvl) begin
            fail_count++;
            conclude();
        end
    endtask

    // ----------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------
    task automatic power_up();
        repeat (20) @(posedge pclk);
        check1(core_reset_n, 1'b0);
        check1(sfr_reset_n | irq_timer_enable, 1'b0);
        check1(rst_pin_oe, 1'b1);
        supply_ok <= 1'b1;
        wait_core(1'b1);
        check1(n >= DLY + 2, 1'b1);
        check1(irq_timer_enable, 1'b1);
        check32({16'h0, fetch_address}, 32'h0);
        check32({24'h0, port_latch}, 32'hFF);
        check32({28'h0, watchdog_clk_div}, 32'hC);
        check32({26'h0, osc_internal_sel, watchdog_enable, port_open_drain,
                 weak_pullup_en, sfr_reset_n, ram_reset_n}, 32'h3F);
        check1(rst_pin_out | rst_pin_oe, 1'b0);
        apb(`RST_CAUSE_ADDR, 1'b0, 32'h0);
        check32(rd & 32'h2, 32'h2);
        apb(`MON_CTRL_ADDR, 1'b0, 32'h0);
        check32(rd, 32'hC0);
        apb(12'h020, 1'b0, 32'h0);
        check32({rd[31:1], err}, 32'h1);
    endtask
    task automatic pin_reset();
        ext_low <= 1'b1;
        wait_core(1'b0);
        check1(rst_pin_oe, 1'b0);
        repeat (5) @(posedge pclk);
        ext_low <= 1'b0;
        wait_core(1'b1);
        apb(`RST_CAUSE_ADDR, 1'b0, 32'h0);
        check32(rd & 32'h3, 32'h1);
    endtask
    task automatic irq_and_soft();
        apb(`MON_CTRL_ADDR, 1'b1, 32'h20);
        check32({30'h0, supply_monitor_enable, supply_threshold_high},
                32'h1);
        apb(`IRQ_STATUS_ADDR, 1'b1, 32'h7);
        apb(`IRQ_MASK_ADDR, 1'b1, 32'h1);
        check1(irq, 1'b0);
        supply_ok <= 1'b0;
        repeat (10) @(posedge pclk);
        check1(core_reset_n, 1'b1);
        check1(irq, 1'b1);
        apb(`MON_CTRL_ADDR, 1'b0, 32'h0);
        check32(rd, 32'h20);
        apb(`IRQ_MASK_ADDR, 1'b1, 32'h0);
        repeat (2) @(posedge pclk);
        check1(irq, 1'b0);
        apb(`IRQ_MASK_ADDR, 1'b1, 32'h1);
        repeat (2) @(posedge pclk);
        check1(irq, 1'b1);
        apb(`IRQ_STATUS_ADDR, 1'b1, 32'h1);
        repeat (2) @(posedge pclk);
        check1(irq, 1'b0);
        supply_ok <= 1'b1;
        apb(`RST_CAUSE_ADDR, 1'b1, 32'h10);
        wait_core(1'b0);
        wait_core(1'b1);
        apb(`MON_CTRL_ADDR, 1'b0, 32'h0);
        check32(rd, 32'h40);
        apb(`RST_CAUSE_ADDR, 1'b0, 32'h0);
        check32(rd & 32'h12, 32'h10);
    endtask
    task automatic por_again();
        presetn <= 1'b0;
        @(posedge pclk);
        check1(core_reset_n | ~rst_pin_oe, 1'b0);
        repeat (9) @(posedge pclk);
        presetn <= 1'b1;
        wait_core(1'b1);
        apb(`MON_CTRL_ADDR, 1'b0, 32'h0);
        check32(rd, 32'hC0);
        apb(`RST_CAUSE_ADDR, 1'b0, 32'h0);
        check32(rd & 32'h13, 32'h2);
    endtask
    task automatic monitor_reset();
        apb(`MON_CTRL_ADDR, 1'b1, 32'h80);
        repeat (4) @(posedge pclk);
        apb(`RST_CAUSE_ADDR, 1'b1, 32'h2);
        check1(supply_monitor_enable, 1'b1);
        supply_ok <= 1'b0;
        wait_core(1'b0);
        check1(rst_pin_oe, 1'b1);
        repeat (30) @(posedge pclk);
        check1(core_reset_n, 1'b0);
        supply_ok <= 1'b1;
        wait_core(1'b1);
        check1(n < DLY, 1'b1);
    endtask

    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end
    initial begin
        fail_count = 0;
        comparisons = 0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h0;
        pwdata = 32'h0;
        supply_ok = 1'b0;
        ext_low = 1'b0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        power_up();
        pin_reset();
        irq_and_soft();
        por_again();
        monitor_reset();
        conclude();
    end
endmodule
`default_nettype wire

// >>> rtl/level_sync.v
// Purpose: two-flop synchroniser for asynchronous levels
// Assumes: input may change at any time
// Notes:   first stage is read only by the second stage
`default_nettype none

module level_sync #(
    parameter RESET_VALUE = 1'b0
) (
    // clock and reset
    input  wire pclk,
    input  wire presetn,
    // level
    input  wire async_in,
    output reg  sync_out
);

    reg meta;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta     <= RESET_VALUE;
            sync_out <= RESET_VALUE;
        end else begin
            meta     <= async_in;
            sync_out <= meta;
        end
    end

endmodule

`default_nettype wire

// >>> rtl/reset_seq_map.vh
// Purpose: offsets, field positions, reset values and timing counts
// Assumes: 32-bit APB data, one aligned word per register
// Notes:   included by the reset sequencer
`ifndef RESET_SEQ_MAP_VH
`define RESET_SEQ_MAP_VH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define RST_CAUSE_ADDR      12'h000
`define MON_CTRL_ADDR       12'h004
`define IRQ_STATUS_ADDR     12'h008
`define IRQ_MASK_ADDR       12'h00C
`define SEQ_STATE_ADDR      12'h010

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define PIN_FLAG_BIT        0
`define POR_FLAG_BIT        1
`define SOFT_FLAG_BIT       4
`define MON_EN_BIT          7
`define MON_STAT_BIT        6
`define MON_LVL_BIT         5
`define IRQ_LOW_BIT         0
`define IRQ_OK_BIT          1
`define IRQ_EXIT_BIT        2

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define PORT_LATCH_RESET    8'hFF
`define FETCH_ADDR_RESET    16'h0000
`define WDT_DIV_RESET       4'hC
`define IRQ_MASK_RESET      3'h0

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define PCLK_PERIOD_NS      25
`define POR_DELAY_NS        300000
`define POR_DELAY_CYC \
    ((`POR_DELAY_NS + `PCLK_PERIOD_NS - 1) / `PCLK_PERIOD_NS)
`define SOFT_HOLD_CYC       4'h4
`define PIN_GUARD_CYC       2'h3

`endif

// >>> rtl/reset_source_sequencer.v
// Purpose: reset state entry, release and reset-cause bookkeeping
// Assumes: presetn is the power-on reset; supply comparator is async
// Notes:
// Notes on behaviour
// [RULE_01] reset halts core, resets registers, stops interrupts
// [RULE_02] data memory kept; stack pointer reset
// [RULE_03] port latches all ones, open-drain, pullups on
// [RULE_04] drive reset pin low for power resets
// [RULE_05] exit clears counter, selects internal oscillator
// [RULE_06] watchdog on, clocked by sysclk over twelve
// [RULE_07] fetch always starts at address zero
// [RULE_08] power-up waits for supply, then release delay
// [RULE_09] power-on flag set on power-up, else cleared
// [RULE_10] monitor enable forced by power-on, else kept
// [RULE_11] low supply drives pin, holds core in reset
// [RULE_12] monitor reset release has no extra delay
// [RULE_13] software enables monitor before selecting it
// [RULE_14] read-only live supply status bit
// [RULE_15] monitor resets need enable and selection
// [RULE_16] async assertion, release on one clock edge
//
// Implementation choices: the address map and the APB register port.
`default_nettype none
`include "reset_seq_map.vh"

module reset_source_sequencer #(
    parameter POR_DELAY_CYCLES = `POR_DELAY_CYC
) (
    // clock and power-on reset
    input  wire        pclk,
    input  wire        presetn,
    // apb slave
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    // analogue supply monitor
    input  wire        supply_above,
    output reg         supply_monitor_enable,
    output reg         supply_threshold_high,
    // open-drain reset pin
    input  wire        rst_pin_in,
    output reg         rst_pin_out,
    output reg         rst_pin_oe,
    // core and peripherals
    output reg         core_reset_n,
    output reg         sfr_reset_n,
    output reg         ram_reset_n,
    output reg  [15:0] fetch_address,
    output reg         osc_internal_sel,
    output reg         watchdog_enable,
    output reg  [3:0]  watchdog_clk_div,
    output reg         irq_timer_enable,
    // port defaults
    output reg  [7:0]  port_latch,
    output reg         port_open_drain,
    output reg         weak_pullup_en,
    // interrupt
    output reg         irq
);

    // ------------------------------------------------------------
    // states
    // ------------------------------------------------------------
    localparam [2:0] ST_POR_WAIT  = 3'h0;
    localparam [2:0] ST_POR_DELAY = 3'h1;
    localparam [2:0] ST_RUN       = 3'h2;
    localparam [2:0] ST_MON       = 3'h3;
    localparam [2:0] ST_PIN       = 3'h4;
    localparam [2:0] ST_SOFT      = 3'h5;
    localparam [15:0] DELAY_LAST = POR_DELAY_CYCLES[15:0] - 16'h0001;

    // ------------------------------------------------------------
    // synchronised inputs
    // ------------------------------------------------------------
    wire supply_ok;
    wire pin_level;

    level_sync #(.RESET_VALUE(1'b0)) u_supply_sync (
        .pclk     (pclk),
        .presetn  (presetn),
        .async_in (supply_above),
        .sync_out (supply_ok)
    );

    level_sync #(.RESET_VALUE(1'b1)) u_pin_sync (
        .pclk     (pclk),
        .presetn  (presetn),
        .async_in (rst_pin_in),
        .sync_out (pin_level)
    );

    // ------------------------------------------------------------
    // state and software-visible registers
    // ------------------------------------------------------------
    reg  [2:0]  state;
    reg  [2:0]  next_state;
    reg  [15:0] delay_cnt;
    reg  [3:0]  soft_cnt;
    reg  [1:0]  pin_guard;
    reg         supply_ok_d;
    reg         power_on_flag;
    reg         pin_flag;
    reg         soft_flag;
    reg         monitor_select;
    reg  [2:0]  irq_status;
    reg  [2:0]  irq_mask;

    wire        access     = psel & penable & pready;
    wire        wr         = access & pwrite;
    wire        rd_phase   = psel & penable & ~pready;
    wire        in_run     = (state == ST_RUN);
    wire        mon_trip   = supply_monitor_enable & monitor_select
                             & ~supply_ok; // [RULE_15]
    wire        pin_trip   = ~pin_level & ~rst_pin_oe
                             & (pin_guard == 2'h0);
    wire        soft_req   = wr & (paddr == `RST_CAUSE_ADDR)
                             & pwdata[`SOFT_FLAG_BIT];
    wire        leave_rst  = ~in_run & (next_state == ST_RUN);
    wire [2:0]  events;

    assign events[`IRQ_LOW_BIT]  = supply_ok_d & ~supply_ok;
    assign events[`IRQ_OK_BIT]   = ~supply_ok_d & supply_ok;
    assign events[`IRQ_EXIT_BIT] = leave_rst;

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always @* begin
        next_state = state;
        case (state)
            ST_POR_WAIT: if (supply_ok) next_state = ST_POR_DELAY; // [RULE_08]
            ST_POR_DELAY: begin
                if (!supply_ok) begin
                    next_state = ST_POR_WAIT;
                end else if (delay_cnt == DELAY_LAST) begin
                    next_state = ST_RUN; // [RULE_08]
                end
            end
            ST_RUN: begin
                if (mon_trip) begin
                    next_state = ST_MON; // [RULE_11]
                end else if (pin_trip) begin
                    next_state = ST_PIN;
                end else if (soft_req) begin
                    next_state = ST_SOFT;
                end
            end
            ST_MON:  if (supply_ok) next_state = ST_RUN; // [RULE_12]
            ST_PIN:  if (pin_level) next_state = ST_RUN;
            ST_SOFT: if (soft_cnt == `SOFT_HOLD_CYC) next_state = ST_RUN;
            default: next_state = ST_POR_WAIT;
        endcase
    end

    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state       <= ST_POR_WAIT;
            delay_cnt   <= 16'h0000;
            soft_cnt    <= 4'h0;
            pin_guard   <= 2'h0;
            supply_ok_d <= 1'b0;
        end else begin
            state       <= next_state;
            supply_ok_d <= supply_ok;
            if (state == ST_POR_DELAY) begin
                delay_cnt <= delay_cnt + 16'h0001;
            end else begin
                delay_cnt <= 16'h0000;
            end
            if (state == ST_SOFT) begin
                soft_cnt <= soft_cnt + 4'h1;
            end else begin
                soft_cnt <= 4'h0;
            end
            if (rst_pin_oe) begin
                pin_guard <= `PIN_GUARD_CYC;
            end else if (pin_guard != 2'h0) begin
                pin_guard <= pin_guard - 2'h1;
            end
        end
    end

    // ------------------------------------------------------------
    // reset outputs; all but ram_reset_n assert with presetn, release on one edge
    // ------------------------------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            core_reset_n     <= 1'b0; // [RULE_16]
            sfr_reset_n      <= 1'b0; // [RULE_01]
            ram_reset_n      <= 1'b1; // [RULE_02]
            irq_timer_enable <= 1'b0;
            rst_pin_out      <= 1'b0;
            rst_pin_oe       <= 1'b1; // [RULE_04]
        end else begin
            core_reset_n     <= (next_state == ST_RUN); // [RULE_16]
            sfr_reset_n      <= (next_state == ST_RUN); // [RULE_01] [RULE_02]
            ram_reset_n      <= 1'b1; // [RULE_02]
            irq_timer_enable <= (next_state == ST_RUN); // [RULE_01]
            rst_pin_out      <= 1'b0;
            rst_pin_oe       <= (next_state == ST_POR_WAIT) // [RULE_04]
                                | (next_state == ST_POR_DELAY)
                                | (next_state == ST_MON); // [RULE_11]
        end
    end

    // ------------------------------------------------------------
    // defaults loaded while in reset
    // ------------------------------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fetch_address    <= `FETCH_ADDR_RESET;
            osc_internal_sel <= 1'b1;
            watchdog_enable  <= 1'b1;
            watchdog_clk_div <= `WDT_DIV_RESET;
            port_latch       <= `PORT_LATCH_RESET;
            port_open_drain  <= 1'b1;
            weak_pullup_en   <= 1'b1;
        end else if (!in_run) begin
            fetch_address    <= `FETCH_ADDR_RESET; // [RULE_05] [RULE_07]
            osc_internal_sel <= 1'b1; // [RULE_05]
            watchdog_enable  <= 1'b1; // [RULE_06]
            watchdog_clk_div <= `WDT_DIV_RESET; // [RULE_06]
            port_latch       <= `PORT_LATCH_RESET; // [RULE_03]
            port_open_drain  <= 1'b1; // [RULE_03]
            weak_pullup_en   <= 1'b1; // [RULE_03]
        end
    end

    // ------------------------------------------------------------
    // reset cause and supply monitor control
    // ------------------------------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            power_on_flag         <= 1'b0;
            pin_flag              <= 1'b0;
            soft_flag             <= 1'b0;
            monitor_select        <= 1'b1;
            supply_monitor_enable <= 1'b1; // [RULE_10]
            supply_threshold_high <= 1'b0;
        end else begin
            if (leave_rst) begin
                power_on_flag <= (state == ST_POR_DELAY); // [RULE_09]
                pin_flag      <= (state == ST_PIN);
                soft_flag     <= (state == ST_SOFT);
            end
            if (!in_run) begin
                supply_threshold_high <= 1'b0;
            end else if (wr && paddr == `MON_CTRL_ADDR) begin
                supply_monitor_enable <= pwdata[`MON_EN_BIT];
                supply_threshold_high <= pwdata[`MON_LVL_BIT];
            end
            if (wr && paddr == `RST_CAUSE_ADDR) begin
                monitor_select <= pwdata[`POR_FLAG_BIT]; // [RULE_13]
            end
        end
    end

    // ------------------------------------------------------------
    // interrupt status and mask
    // ------------------------------------------------------------
    genvar i;
    generate
        for (i = 0; i < 3; i = i + 1) begin : g_irq
            always @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    irq_status[i] <= 1'b0;
                end else if (events[i]) begin
                    irq_status[i] <= 1'b1;
                end else if (wr && paddr == `IRQ_STATUS_ADDR
                             && pwdata[i]) begin
                    irq_status[i] <= 1'b0;
                end
            end
        end
    endgenerate

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_mask <= `IRQ_MASK_RESET;
            irq      <= 1'b0;
        end else begin
            if (wr && paddr == `IRQ_MASK_ADDR) irq_mask <= pwdata[2:0];
            irq <= |(irq_status & irq_mask);
        end
    end

    // ------------------------------------------------------------
    // apb slave: one wait state, error on unmapped address
    // ------------------------------------------------------------
    reg [31:0] rd_mux;
    reg        rd_err;

    always @* begin
        rd_mux = 32'h0000_0000;
        rd_err = 1'b0;
        if (paddr == `RST_CAUSE_ADDR) begin
            rd_mux[`POR_FLAG_BIT]  = power_on_flag; // [RULE_09]
            rd_mux[`PIN_FLAG_BIT]  = pin_flag & ~power_on_flag;
            rd_mux[`SOFT_FLAG_BIT] = soft_flag & ~power_on_flag;
        end else if (paddr == `MON_CTRL_ADDR) begin
            rd_mux[`MON_EN_BIT]   = supply_monitor_enable;
            rd_mux[`MON_STAT_BIT] = supply_ok; // [RULE_14]
            rd_mux[`MON_LVL_BIT]  = supply_threshold_high;
        end else if (paddr == `IRQ_STATUS_ADDR) begin
            rd_mux[2:0] = irq_status;
        end else if (paddr == `IRQ_MASK_ADDR) begin
            rd_mux[2:0] = irq_mask;
        end else if (paddr == `SEQ_STATE_ADDR) begin
            rd_mux[2:0]   = state;
            rd_mux[31:16] = delay_cnt;
        end else begin
            rd_err = 1'b1;
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= rd_phase;
            pslverr <= rd_phase & rd_err;
            prdata  <= (rd_phase & ~pwrite) ? rd_mux : 32'h0000_0000;
        end
    end

endmodule

`default_nettype wire
